// [hdl/afp_pkg.sv]
// Shared constants, types and decoders of the ADC output format and power control
package afp_pkg;

  localparam int         AFP_WORD_W  = 8;
  localparam int         AFP_UNITS   = 2;

  // Three-level strap codes
  localparam logic [1:0] AFP_LVL_LOW   = 2'h0;
  localparam logic [1:0] AFP_LVL_FLOAT = 2'h1;
  localparam logic [1:0] AFP_LVL_HIGH  = 2'h2;

  typedef enum logic [2:0] {
    AFP_FMT_BIN  = 3'b001,
    AFP_FMT_TWOS = 3'b010,
    AFP_FMT_GRAY = 3'b100
  } afp_fmt_t;

  typedef enum logic [2:0] {
    AFP_OM_CMOS  = 3'b001,
    AFP_OM_LVDS3 = 3'b010,
    AFP_OM_LVDS2 = 3'b100
  } afp_omode_t;

  typedef enum logic [3:0] {
    AFP_PS_RUN   = 4'b0001,
    AFP_PS_NAP   = 4'b0010,
    AFP_PS_SLEEP = 4'b0100,
    AFP_PS_WAKE  = 4'b1000
  } afp_pstate_t;

  typedef enum logic [4:0] {
    AFP_HS_IDLE   = 5'b00001,
    AFP_HS_SETUP  = 5'b00010,
    AFP_HS_WRITE  = 5'b00100,
    AFP_HS_HOLD   = 5'b01000,
    AFP_HS_SETTLE = 5'b10000
  } afp_hstate_t;

  // Device configuration registers
  localparam logic [7:0] AFP_REG_INDEX = 8'h05;
  localparam logic [7:0] AFP_REG_POWER = 8'h19;
  localparam logic [7:0] AFP_REG_OMODE = 8'h73;
  localparam logic [7:0] AFP_REG_FMT   = 8'h74;
  localparam int         AFP_OVR_EN_BIT = 4;
  localparam int         AFP_PWR_LSB    = 1;
  localparam logic [2:0] AFP_PWR_RUN   = 3'b001;
  localparam logic [2:0] AFP_PWR_NAP   = 3'b010;
  localparam logic [2:0] AFP_PWR_SLEEP = 3'b100;
  localparam logic [7:0] AFP_WAKE_WORD = 8'h02;

  // Timing
  localparam int AFP_MCLK_NS        = 100;
  localparam int AFP_NAP_WAKE_NS    = 2750;
  localparam int AFP_NAP_WAKE_CYC   = AFP_NAP_WAKE_NS / AFP_MCLK_NS;
  localparam int AFP_SLEEP_WAKE_NS  = 1000000;
  localparam int AFP_SLEEP_WAKE_CYC = AFP_SLEEP_WAKE_NS / AFP_MCLK_NS;
  localparam int AFP_CS_SETUP_NS    = 150000;
  localparam int AFP_CS_SETUP_CYC   = (AFP_CS_SETUP_NS + AFP_MCLK_NS - 1) / AFP_MCLK_NS;
  localparam int AFP_CAL_NS         = 200000000;
  localparam int AFP_CAL_CYC        = AFP_CAL_NS / AFP_MCLK_NS;
  localparam int AFP_CFG_HOLD_CYC   = 4;

  // Host register map and fields
  localparam logic [3:0] AFP_H_CTRL = 4'h0;
  localparam logic [3:0] AFP_H_ADDR = 4'h1;
  localparam logic [3:0] AFP_H_DATA = 4'h2;
  localparam logic [3:0] AFP_H_CMD  = 4'h3;
  localparam logic [3:0] AFP_H_STAT = 4'h4;
  localparam logic [3:0] AFP_H_WORD = 4'h5;
  localparam int AFP_CTRL_KEEPCS = 0;
  localparam int AFP_CTRL_RECAL  = 1;
  localparam int AFP_CTRL_FMT    = 2;
  localparam int AFP_CMD_WRITE   = 0;
  localparam int AFP_CMD_WAKE    = 1;

  function automatic afp_fmt_t afp_lvl_fmt(input logic [1:0] lvl);
    if (lvl == AFP_LVL_LOW) return AFP_FMT_BIN;
    else if (lvl == AFP_LVL_HIGH) return AFP_FMT_GRAY;
    else return AFP_FMT_TWOS;
  endfunction : afp_lvl_fmt

  function automatic afp_omode_t afp_lvl_omode(input logic [1:0] lvl);
    if (lvl == AFP_LVL_LOW) return AFP_OM_CMOS;
    else if (lvl == AFP_LVL_HIGH) return AFP_OM_LVDS2;
    else return AFP_OM_LVDS3;
  endfunction : afp_lvl_omode

  function automatic logic [2:0] afp_lvl_pwr(input logic [1:0] lvl);
    if (lvl == AFP_LVL_LOW) return AFP_PWR_RUN;
    else if (lvl == AFP_LVL_HIGH) return AFP_PWR_NAP;
    else return AFP_PWR_SLEEP;
  endfunction : afp_lvl_pwr

endpackage : afp_pkg

// [hdl/afp_link_if.sv]
// Link between converter output stage and its capture and configuration host
`timescale 1ns/10ps
`default_nettype none
interface afp_link_if #(parameter int WORD_W = 8);
  logic [WORD_W-1:0] data;
  logic              data_oe;
  logic              data_output_clock;
  logic              data_output_clock_oe;
  logic              over_range;
  logic              over_range_oe;
  logic              serial_chip_select_n;
  logic              cfg_wr_toggle;
  logic [7:0]        cfg_addr;
  logic [7:0]        cfg_data;
  logic              calibration_reset_n;

  modport dev_mp (
    output data, data_oe, data_output_clock, data_output_clock_oe,
    output over_range, over_range_oe,
    input  serial_chip_select_n, cfg_wr_toggle, cfg_addr, cfg_data,
    input  calibration_reset_n
  );

  modport host_mp (
    input  data, data_oe, data_output_clock, data_output_clock_oe,
    input  over_range, over_range_oe,
    output serial_chip_select_n, cfg_wr_toggle, cfg_addr, cfg_data,
    output calibration_reset_n
  );
endinterface : afp_link_if
`default_nettype wire

// [hdl/afp_encode.sv]
// Saturation, full-scale detect and output coding of one conversion result
`timescale 1ns/10ps
`default_nettype none
module afp_encode
  import afp_pkg::*;
#(
  parameter int WORD_W = AFP_WORD_W
) (
  input  wire logic [WORD_W-1:0] i_bin,
  input  wire logic              i_over,
  input  wire afp_fmt_t          i_fmt,
  output logic      [WORD_W-1:0] o_code,
  output logic                   o_full
);
  logic [WORD_W-1:0] sat;

  always_comb begin
    sat    = i_over ? {WORD_W{1'b1}} : i_bin;
    o_full = (sat == {WORD_W{1'b1}});
    unique case (i_fmt)
      AFP_FMT_TWOS: o_code = {~sat[WORD_W-1], sat[WORD_W-2:0]};
      AFP_FMT_GRAY: o_code = sat ^ (sat >> 1);
      default:      o_code = sat;
    endcase
  end
endmodule : afp_encode
`default_nettype wire

// [hdl/afp_device.sv]
// Converter output stage: coding, DDR output, over-range and power states
`timescale 1ns/10ps
`default_nettype none
module afp_device
  import afp_pkg::*;
#(
  parameter int WORD_W         = AFP_WORD_W,
  parameter int UNITS          = AFP_UNITS,
  parameter int SLEEP_WAKE_CYC = AFP_SLEEP_WAKE_CYC,
  parameter int CAL_CYC        = AFP_CAL_CYC
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire logic [WORD_W-1:0] i_sample,
  input  wire logic              i_sample_over,
  input  wire logic [1:0]        i_output_mode_strap,
  input  wire logic [1:0]        i_power_state_strap,
  input  wire logic [1:0]        i_data_format_strap,
  output logic      [2:0]        o_out_mode,
  output logic      [2:0]        o_data_format,
  output logic      [3:0]        o_power_state,
  output logic                   o_cal_busy,
  afp_link_if.dev_mp             link
);
  localparam int WK_W  = $clog2(SLEEP_WAKE_CYC + 1);
  localparam int CS_W  = $clog2(AFP_CS_SETUP_CYC + 1);
  localparam int CAL_W = $clog2(CAL_CYC + 1);

  if (WORD_W < 2 || UNITS < 1 || UNITS > 8 || SLEEP_WAKE_CYC < AFP_NAP_WAKE_CYC
      || CAL_CYC < 1) begin : g_bad_param
    $error("afp_device: unsupported parameter value");
  end

  typedef struct packed {
    logic [1:0]             cs_s;
    logic [2:0]             wr_s;
    logic [7:0]             addr_s1;
    logic [7:0]             addr_s2;
    logic [7:0]             wdat_s1;
    logic [7:0]             wdat_s2;
    logic [1:0]             cal_s;
    logic [5:0]             strap_s1;
    logic [5:0]             strap_s2;
    logic [1:0]             strap_age;
    logic [1:0]             pwr_strap;
    logic [4:0]             omode_reg;
    logic [4:0]             fmt_reg;
    logic [UNITS-1:0]       unit_sel;
    logic [UNITS-1:0][2:0]  unit_pwr;
    afp_pstate_t            pstate;
    logic [WK_W-1:0]        wake_cnt;
    logic [CS_W-1:0]        cs_cnt;
    logic                   regs_alive;
    logic [CAL_W-1:0]       cal_cnt;
    logic                   cal_busy;
    logic                   dclk;
    logic [WORD_W-1:0]      data;
    logic                   ovr;
    logic                   oe;
    afp_omode_t             omode;
    afp_fmt_t               fmt;
  } afp_dev_st_t;

  localparam afp_dev_st_t ST_RST = '{
    cs_s: 2'h3, wr_s: 3'h0, addr_s1: 8'h00, addr_s2: 8'h00, wdat_s1: 8'h00,
    wdat_s2: 8'h00, cal_s: 2'h0, strap_s1: 6'h00, strap_s2: 6'h00,
    strap_age: 2'h0, pwr_strap: AFP_LVL_LOW, omode_reg: 5'h00, fmt_reg: 5'h00,
    unit_sel: '1, unit_pwr: '0, pstate: AFP_PS_RUN, wake_cnt: '0, cs_cnt: '0,
    regs_alive: 1'b1, cal_cnt: CAL_W'(CAL_CYC - 1), cal_busy: 1'b1,
    dclk: 1'b0, data: '0, ovr: 1'b1, oe: 1'b0, omode: AFP_OM_CMOS,
    fmt: AFP_FMT_BIN
  };

  afp_dev_st_t q;
  afp_dev_st_t n;
  logic [WORD_W-1:0] code;
  logic              full;
  logic              wr_evt;
  logic              cfg_ok;
  logic [2:0]        tgt;
  logic [1:0]        om_lvl;
  logic [1:0]        fm_lvl;

  // Worst state over all units; unprogrammed units follow the strap
  function automatic logic [2:0] afp_target(input logic [UNITS-1:0][2:0] pw,
                                            input logic [1:0] strap);
    logic [2:0] w;
    logic [2:0] u;
    w = AFP_PWR_RUN;
    for (int i = 0; i < UNITS; i++) begin
      u = (pw[i] == AFP_PWR_RUN || pw[i] == AFP_PWR_NAP || pw[i] == AFP_PWR_SLEEP)
          ? pw[i] : afp_lvl_pwr(strap);
      if (u == AFP_PWR_SLEEP || (u == AFP_PWR_NAP && w == AFP_PWR_RUN)) w = u;
    end
    return w;
  endfunction : afp_target

  afp_encode #(.WORD_W(WORD_W)) u_encode (
    .i_bin  (i_sample),
    .i_over (i_sample_over),
    .i_fmt  (q.fmt),
    .o_code (code),
    .o_full (full)
  );

  always_comb begin
    n = q;
    // Pin synchronisers
    n.cs_s     = {q.cs_s[0], link.serial_chip_select_n};
    n.wr_s     = {q.wr_s[1:0], link.cfg_wr_toggle};
    n.addr_s1  = link.cfg_addr;
    n.addr_s2  = q.addr_s1;
    n.wdat_s1  = link.cfg_data;
    n.wdat_s2  = q.wdat_s1;
    n.cal_s    = {q.cal_s[0], link.calibration_reset_n};
    n.strap_s1 = {i_output_mode_strap, i_power_state_strap, i_data_format_strap};
    n.strap_s2 = q.strap_s1;
    if (q.strap_age != 2'h3) n.strap_age = q.strap_age + 2'h1;
    if (q.strap_age == 2'h2) n.pwr_strap = q.strap_s2[3:2];

    // Serial port powered unless asleep with select raised, then held low too briefly
    if (q.cs_s[1]) n.cs_cnt = '0;
    else if (q.cs_cnt != CS_W'(AFP_CS_SETUP_CYC)) n.cs_cnt = q.cs_cnt + 1'b1;
    if (q.pstate != AFP_PS_SLEEP) n.regs_alive = 1'b1;
    else if (q.cs_s[1]) n.regs_alive = 1'b0;
    cfg_ok = q.pstate != AFP_PS_SLEEP || q.regs_alive
             || q.cs_cnt == CS_W'(AFP_CS_SETUP_CYC);
    wr_evt = (q.wr_s[1] ^ q.wr_s[2]) && !q.cs_s[1] && cfg_ok;
    if (wr_evt) begin
      if (q.addr_s2 == AFP_REG_INDEX) n.unit_sel = q.wdat_s2[UNITS-1:0];
      if (q.addr_s2 == AFP_REG_OMODE) n.omode_reg = q.wdat_s2[4:0];
      if (q.addr_s2 == AFP_REG_FMT) n.fmt_reg = q.wdat_s2[4:0];
      if (q.addr_s2 == AFP_REG_POWER) begin
        for (int i = 0; i < UNITS; i++) begin
          if (q.unit_sel[i]) n.unit_pwr[i] = q.wdat_s2[AFP_PWR_LSB+:3];
        end
      end
    end

    // Programmed selections win over the straps
    om_lvl  = q.omode_reg[AFP_OVR_EN_BIT] ? q.omode_reg[1:0] : q.strap_s2[5:4];
    fm_lvl  = q.fmt_reg[AFP_OVR_EN_BIT] ? q.fmt_reg[1:0] : q.strap_s2[1:0];
    n.omode = afp_lvl_omode(om_lvl);
    n.fmt   = afp_lvl_fmt(fm_lvl);

    // Power states
    tgt = afp_target(q.unit_pwr, q.pwr_strap);
    unique case (q.pstate)
      AFP_PS_RUN: begin
        if (tgt == AFP_PWR_SLEEP) n.pstate = AFP_PS_SLEEP;
        else if (tgt == AFP_PWR_NAP) n.pstate = AFP_PS_NAP;
      end
      AFP_PS_NAP: begin
        if (tgt == AFP_PWR_SLEEP) n.pstate = AFP_PS_SLEEP;
        else if (tgt == AFP_PWR_RUN) begin
          n.pstate   = AFP_PS_WAKE;
          n.wake_cnt = WK_W'(AFP_NAP_WAKE_CYC - 1);
        end
      end
      AFP_PS_SLEEP: begin
        if (tgt != AFP_PWR_SLEEP) begin
          n.pstate   = AFP_PS_WAKE;
          n.wake_cnt = WK_W'(SLEEP_WAKE_CYC - 1);
        end
      end
      AFP_PS_WAKE: begin
        if (tgt == AFP_PWR_SLEEP) n.pstate = AFP_PS_SLEEP;
        else if (tgt == AFP_PWR_NAP) n.pstate = AFP_PS_NAP;
        else if (q.wake_cnt == '0) n.pstate = AFP_PS_RUN;
        else n.wake_cnt = q.wake_cnt - 1'b1;
      end
      default: n.pstate = AFP_PS_RUN;
    endcase

    // Calibration after the reset pin rises
    if (!q.cal_s[1]) begin
      n.cal_busy = 1'b1;
      n.cal_cnt  = CAL_W'(CAL_CYC - 1);
    end else if (q.cal_busy) begin
      if (q.cal_cnt == '0) n.cal_busy = 1'b0;
      else n.cal_cnt = q.cal_cnt - 1'b1;
    end

    // Output stage: one word per sample, both clock edges carry data
    n.oe   = (n.pstate == AFP_PS_RUN) && q.strap_age == 2'h3;
    n.dclk = q.cal_s[1] && n.oe ? ~q.dclk : 1'b0;
    n.data = code;
    n.ovr  = !q.cal_s[1] || q.cal_busy || full;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  assign link.data                 = q.data;
  assign link.data_oe              = q.oe;
  assign link.data_output_clock    = q.dclk;
  assign link.data_output_clock_oe = q.oe;
  assign link.over_range           = q.ovr;
  assign link.over_range_oe        = q.oe;
  assign o_out_mode                = q.omode;
  assign o_data_format             = q.fmt;
  assign o_power_state             = q.pstate;
  assign o_cal_busy                = q.cal_busy;
endmodule : afp_device
`default_nettype wire

// [hdl/afp_host.sv]
// Capture and configuration host: DDR capture, Gray decode, wake sequencing
`timescale 1ns/10ps
`default_nettype none
module afp_host
  import afp_pkg::*;
#(
  parameter int WORD_W        = AFP_WORD_W,
  parameter int WAKE_WAIT_CYC = AFP_SLEEP_WAKE_CYC
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire logic [3:0]        i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  output logic      [WORD_W-1:0] o_word,
  output logic                   o_word_valid,
  output logic                   o_over_range,
  afp_link_if.host_mp            link
);
  localparam int CNT_W = $clog2(WAKE_WAIT_CYC + 1);

  if (WORD_W < 2 || WORD_W > 8 || WAKE_WAIT_CYC < AFP_CS_SETUP_CYC) begin : g_bad_param
    $error("afp_host: unsupported parameter value");
  end

  typedef struct packed {
    logic [2:0]        dclk_s;
    logic [WORD_W-1:0] dat_s1;
    logic [WORD_W-1:0] dat_s2;
    logic [1:0]        ovr_s;
    logic [1:0]        oe_s;
    logic [WORD_W-1:0] word;
    logic              valid;
    logic              over;
    logic [3:0]        ctrl;
    logic [7:0]        addr_reg;
    logic [7:0]        data_reg;
    afp_hstate_t       hs;
    logic [CNT_W-1:0]  cnt;
    logic              is_wake;
    logic              wake_done;
    logic              cs_n;
    logic              wr_tgl;
    logic [7:0]        addr_o;
    logic [7:0]        data_o;
    logic [7:0]        rdata;
  } afp_host_st_t;

  localparam afp_host_st_t ST_RST = '{
    dclk_s: 3'h0, dat_s1: '0, dat_s2: '0, ovr_s: 2'h0, oe_s: 2'h0, word: '0,
    valid: 1'b0, over: 1'b0, ctrl: 4'h0, addr_reg: 8'h00, data_reg: 8'h00,
    hs: AFP_HS_IDLE, cnt: '0, is_wake: 1'b0, wake_done: 1'b0, cs_n: 1'b1,
    wr_tgl: 1'b0, addr_o: 8'h00, data_o: 8'h00, rdata: 8'h00
  };

  afp_host_st_t q;
  afp_host_st_t n;
  logic         go;

  // Gray to binary, each bit from the one just recovered above it
  function automatic logic [WORD_W-1:0] afp_gray2bin(input logic [WORD_W-1:0] g);
    logic [WORD_W-1:0] b;
    b[WORD_W-1] = g[WORD_W-1];
    for (int i = WORD_W - 2; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : afp_gray2bin

  always_comb begin
    n = q;
    n.dclk_s = {q.dclk_s[1:0], link.data_output_clock};
    n.dat_s1 = link.data;
    n.dat_s2 = q.dat_s1;
    n.ovr_s  = {q.ovr_s[0], link.over_range};
    n.oe_s   = {q.oe_s[0], link.data_output_clock_oe};
    n.valid  = 1'b0;
    // Every output clock edge carries one word
    if ((q.dclk_s[1] ^ q.dclk_s[2]) && q.oe_s[1]) begin
      n.valid = 1'b1;
      n.over  = q.ovr_s[1];
      unique case (afp_lvl_fmt(q.ctrl[AFP_CTRL_FMT+:2]))
        AFP_FMT_GRAY: n.word = afp_gray2bin(q.dat_s2);
        AFP_FMT_TWOS: n.word = {~q.dat_s2[WORD_W-1], q.dat_s2[WORD_W-2:0]};
        default:      n.word = q.dat_s2;
      endcase
    end

    n.rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        AFP_H_CTRL: n.rdata = {4'h0, q.ctrl};
        AFP_H_ADDR: n.rdata = q.addr_reg;
        AFP_H_DATA: n.rdata = q.data_reg;
        AFP_H_STAT: n.rdata = {5'h00, q.over, q.hs != AFP_HS_IDLE, q.wake_done};
        AFP_H_WORD: n.rdata = 8'(q.word);
        default:    n.rdata = 8'h00;
      endcase
    end
    go = 1'b0;
    if (i_wr) begin
      if (i_addr == AFP_H_CTRL) n.ctrl = i_wdata[3:0];
      if (i_addr == AFP_H_ADDR) n.addr_reg = i_wdata;
      if (i_addr == AFP_H_DATA) n.data_reg = i_wdata;
      go = i_addr == AFP_H_CMD && q.hs == AFP_HS_IDLE
           && (i_wdata[AFP_CMD_WRITE] || i_wdata[AFP_CMD_WAKE]);
    end

    unique case (q.hs)
      AFP_HS_IDLE: begin
        n.cs_n = ~q.ctrl[AFP_CTRL_KEEPCS];
        if (go) begin
          n.is_wake = i_wdata[AFP_CMD_WAKE];
          n.addr_o  = i_wdata[AFP_CMD_WAKE] ? AFP_REG_POWER : q.addr_reg;
          n.data_o  = i_wdata[AFP_CMD_WAKE] ? AFP_WAKE_WORD : q.data_reg;
          n.cs_n    = 1'b0;
          if (i_wdata[AFP_CMD_WAKE]) n.wake_done = 1'b0;
          if (i_wdata[AFP_CMD_WAKE] && q.cs_n) begin
            n.hs  = AFP_HS_SETUP;
            n.cnt = CNT_W'(AFP_CS_SETUP_CYC - 1);
          end else begin
            n.hs = AFP_HS_WRITE;
          end
        end
      end
      AFP_HS_SETUP: begin
        if (q.cnt == '0) n.hs = AFP_HS_WRITE;
        else n.cnt = q.cnt - 1'b1;
      end
      AFP_HS_WRITE: begin
        n.wr_tgl = ~q.wr_tgl;
        n.hs     = AFP_HS_HOLD;
        n.cnt    = CNT_W'(AFP_CFG_HOLD_CYC - 1);
      end
      AFP_HS_HOLD: begin
        if (q.cnt != '0) n.cnt = q.cnt - 1'b1;
        else begin
          n.cs_n = ~q.ctrl[AFP_CTRL_KEEPCS];
          n.hs   = q.is_wake ? AFP_HS_SETTLE : AFP_HS_IDLE;
          n.cnt  = CNT_W'(WAKE_WAIT_CYC - 1);
        end
      end
      AFP_HS_SETTLE: begin
        if (q.cnt != '0) n.cnt = q.cnt - 1'b1;
        else begin
          n.hs        = AFP_HS_IDLE;
          n.wake_done = 1'b1;
        end
      end
      default: n.hs = AFP_HS_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  assign o_rdata                   = q.rdata;
  assign o_word                    = q.word;
  assign o_word_valid              = q.valid;
  assign o_over_range              = q.over;
  assign link.serial_chip_select_n = q.cs_n;
  assign link.cfg_wr_toggle        = q.wr_tgl;
  assign link.cfg_addr             = q.addr_o;
  assign link.cfg_data             = q.data_o;
  assign link.calibration_reset_n  = ~q.ctrl[AFP_CTRL_RECAL];
endmodule : afp_host
`default_nettype wire

// [dv/afp_link_monitor.sv]
// Link protocol checker for the converter output stage and its host
`timescale 1ns/10ps
`default_nettype none
module afp_link_monitor (
  input wire logic       i_mclk,
  input wire logic       i_rstn,
  input wire logic       data_oe,
  input wire logic       data_output_clock,
  input wire logic       data_output_clock_oe,
  input wire logic       over_range,
  input wire logic       over_range_oe,
  input wire logic       serial_chip_select_n,
  input wire logic       cfg_wr_toggle,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  input wire logic       calibration_reset_n
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  // Cycles since the last configuration write, saturating
  logic [7:0] since_r;
  logic       tog_r;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      since_r <= 8'hff;
      tog_r   <= 1'b0;
    end else begin
      tog_r   <= cfg_wr_toggle;
      since_r <= (cfg_wr_toggle != tog_r) ? 8'h00 : since_r + 8'(since_r != 8'hff);
    end
  end

  clk_half_a: assert property (data_output_clock_oe && $past(data_output_clock_oe)
    && $past(data_output_clock) |-> !data_output_clock) else $error("output clock stuck high");
  oe_same_a: assert property (data_oe == over_range_oe
    && data_oe == data_output_clock_oe && (data_oe || !data_output_clock))
    else $error("output enables differ or clock runs while disabled");
  cal_flag_a: assert property ($fell(calibration_reset_n) |-> ##[1:3] over_range)
    else $error("over-range low after calibration reset");
  cal_clk_a: assert property (!calibration_reset_n [*4] |-> !data_output_clock)
    else $error("output clock runs in calibration reset");
  cal_hold_a: assert property ($rose(calibration_reset_n) && data_oe |-> over_range [*8])
    else $error("over-range dropped during calibration");
  cfg_hold_a: assert property ($changed(cfg_wr_toggle) |->
    ($stable(cfg_addr) && $stable(cfg_data)) [*3]) else $error("config word moved");
  cfg_select_a: assert property ($changed(cfg_wr_toggle) |-> !serial_chip_select_n [*3])
    else $error("config write without select");
  nap_wake_a: assert property ($rose(data_oe) |-> since_r >= 8'h1b)
    else $error("outputs back too early");

  cover property ($rose(data_oe));
  cover property ($fell(calibration_reset_n));
  cover property ($changed(cfg_wr_toggle));
endmodule : afp_link_monitor
`default_nettype wire

// [dv/afp_tb_top.sv]
// Testbench of the output stage joined to its capture host
`timescale 1ns/10ps
`default_nettype none
module adc_output_format_power_ctrl_tb_top;
  import afp_pkg::*;
  logic       i_mclk = 1'b0;
  logic       i_rstn = 1'b0;
  logic [7:0] i_sample = 8'h00, i_wdata = 8'h00, o_rdata, o_word, d, b;
  logic [3:0] i_addr = 4'h0, o_power_state;
  logic [2:0] o_out_mode, o_data_format;
  logic [1:0] i_output_mode_strap = 2'h0, i_power_state_strap = 2'h0;
  logic [1:0] i_data_format_strap = 2'h0;
  logic       i_sample_over = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic       o_cal_busy, o_word_valid, o_over_range;
  logic [7:0] vals [4] = '{8'h00, 8'h80, 8'hfe, 8'h12};
  int         num_errors = 0, num_checks = 0, cnt = 0, n;

  afp_link_if #(.WORD_W(8)) afp_link_if_i ();
  afp_device #(.SLEEP_WAKE_CYC(50), .CAL_CYC(20)) afp_device_i (.i_mclk, .i_rstn,
    .i_sample, .i_sample_over, .i_output_mode_strap, .i_power_state_strap,
    .i_data_format_strap, .o_out_mode, .o_data_format, .o_power_state, .o_cal_busy,
    .link(afp_link_if_i));
  afp_host #(.WAKE_WAIT_CYC(1600)) afp_host_i (.i_mclk, .i_rstn, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_word, .o_word_valid, .o_over_range, .link(afp_link_if_i));
  afp_link_monitor afp_link_monitor_i (.i_mclk, .i_rstn,
    .data_oe(afp_link_if_i.data_oe), .data_output_clock(afp_link_if_i.data_output_clock),
    .data_output_clock_oe(afp_link_if_i.data_output_clock_oe),
    .over_range(afp_link_if_i.over_range), .over_range_oe(afp_link_if_i.over_range_oe),
    .serial_chip_select_n(afp_link_if_i.serial_chip_select_n),
    .cfg_wr_toggle(afp_link_if_i.cfg_wr_toggle), .cfg_addr(afp_link_if_i.cfg_addr),
    .cfg_data(afp_link_if_i.cfg_data), .calibration_reset_n(afp_link_if_i.calibration_reset_n));

  always #50 i_mclk = ~i_mclk;

  task automatic end_of_test();
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  always @(posedge i_mclk) begin
    cnt++;
    if (cnt == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  task automatic cfg(input logic [7:0] a, input logic [7:0] v);
    wr(AFP_H_ADDR, a);
    wr(AFP_H_DATA, v);
    wr(AFP_H_CMD, 8'h01);
    cyc(12);
  endtask : cfg

  task automatic wake(output int k);
    wr(AFP_H_CMD, 8'h02);
    k = 0;
    do begin
      rd(AFP_H_STAT, d);
      k += 2;
    end while (d[1] && k < 5000);
  endtask : wake

  task automatic rst();
    @(posedge i_mclk);
    i_rstn <= 1'b0;
    repeat (5) @(posedge i_mclk);
    i_rstn <= 1'b1;
    cyc(45);
  endtask : rst

  function automatic logic [7:0] enc(input int f, input logic [7:0] v);
    return f == 0 ? v : f == 1 ? v ^ 8'h80 : v ^ (v >> 1);
  endfunction : enc

  initial begin
    rst();
    for (int f = 0; f < 3; f++) begin
      @(posedge i_mclk);
      i_data_format_strap <= 2'(f);
      wr(AFP_H_CTRL, 8'(f << 2));
      for (int k = 0; k < 4; k++) begin
        @(posedge i_mclk);
        i_sample      <= vals[k];
        i_sample_over <= (k == 3);
        cyc(8);
        b = (k == 3) ? 8'hff : vals[k];
        chk(afp_link_if_i.data, enc(f, b));
        chk(afp_link_if_i.over_range, b == 8'hff);
        chk(o_word, b);
        chk(o_over_range, b == 8'hff);
        chk(o_word_valid, 8'h01);
      end
      chk(o_data_format, 8'(1 << f));
    end
    for (int m = 0; m < 3; m++) begin
      @(posedge i_mclk);
      i_output_mode_strap <= 2'(m);
      cyc(5);
      chk(o_out_mode, 8'(1 << m));
    end
    cfg(AFP_REG_OMODE, 8'h10);
    chk(o_out_mode, 8'h01);
    cfg(AFP_REG_FMT, 8'h10);
    chk(afp_link_if_i.data, 8'hff);
    d[0] = afp_link_if_i.data_output_clock;
    cyc(1);
    chk(d[0] ^ afp_link_if_i.data_output_clock, 8'h01);
    cfg(AFP_REG_POWER, 8'h04);
    chk(afp_link_if_i.data_oe, 8'h00);
    wr(AFP_H_DATA, 8'h02);
    wr(AFP_H_CMD, 8'h01);
    n = 0;
    while (afp_link_if_i.data_oe !== 1'b1 && n < 99) begin
      cyc(1);
      n++;
    end
    chk(n >= 27 && n <= 36, 8'h01);
    @(posedge i_mclk);
    i_power_state_strap <= 2'h1;
    rst();
    chk(o_power_state, 8'h04);
    chk(afp_link_if_i.data_oe, 8'h00);
    wake(n);
    chk(n >= 3000 && n < 5000, 8'h01);
    chk(o_power_state, 8'h01);
    wr(AFP_H_CTRL, 8'h01);
    cfg(AFP_REG_POWER, 8'h08);
    chk(o_power_state, 8'h04);
    wake(n);
    chk(n > 1500 && n < 2000, 8'h01);
    chk(afp_link_if_i.data_oe, 8'h01);
    @(posedge i_mclk);
    i_sample_over <= 1'b0;
    wr(AFP_H_CTRL, 8'h02);
    cyc(4);
    chk(afp_link_if_i.over_range, 8'h01);
    wr(AFP_H_CTRL, 8'h00);
    cyc(40);
    chk(o_cal_busy, 8'h00);
    chk(afp_link_if_i.over_range, 8'h00);
    rd(4'hf, d);
    chk(d, 8'h00);
    end_of_test();
  end
endmodule : adc_output_format_power_ctrl_tb_top
`default_nettype wire
